/* File: dv/hwp_host_model.sv */
// Host CPU model that writes one-byte commands to the wake-up port.
// Assumes the bench calls its tasks only after reset has been released.
`timescale 1ns/10ps
module hwp_host_model (
    input  wire logic        clk,
    output logic             host_io_write,
    output logic [15:0]      host_io_addr,
    output logic [7:0]       host_io_data
);
    initial begin
        host_io_write = 1'b0;
        host_io_addr  = 16'h0000;
        host_io_data  = 8'h00;
    end

    // Released lines show the inverse so stale values never match
    task automatic port_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk);
        host_io_write <= 1'b1;
        host_io_addr  <= addr;
        host_io_data  <= data;
        @(posedge clk);
        host_io_write <= 1'b0;
        host_io_addr  <= ~addr;
        host_io_data  <= ~data;
        #1;
    endtask

    task automatic link(input logic [15:0] addr);
        port_write(addr, hwp_pkg::CMD_CLEAR);
        port_write(addr, hwp_pkg::CMD_ATTENTION);
    endtask
endmodule // hwp_host_model

/* File: dv/hwp_port_match_n_bench.sv */
// Self-checking bench for the wake-up port, boot decode and interrupt latch.
// Assumes a host model on the port and processor strobes driven here.
`timescale 1ns/10ps
module hwp_port_match_n_bench;
    localparam logic [15:0] JW = 16'h12A4;
    localparam logic [15:0] JW_ALT = 16'h5B3C;
    logic [15:0] wake_jumpers, jw_now;
    logic        clk, reset, host_io_write, addr16_strap, width16_strap;
    logic        page_last_strap, proc_fetch, local_io_write, local_data_bit8;
    logic [15:0] host_io_addr, local_io_addr, fetch_data;
    logic [7:0]  host_io_data, host_irq_n;
    logic [2:0]  irq_select_strap;
    logic [19:0] proc_fetch_addr;
    logic        port_match_n, controller_reset_n, attention_request;
    logic        processor_attention_in, switch_read_strobe_n, local_write_decode0_n;
    logic        fetch_ack, first_attention_pending, page_last, interrupt_latch;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    hwp_host_model host_u (.clk(clk), .host_io_write(host_io_write),
        .host_io_addr(host_io_addr), .host_io_data(host_io_data));

    hwp_port_match_n dut_u (.clk(clk), .reset(reset), .host_io_write(host_io_write),
        .host_io_addr(host_io_addr), .host_io_data(host_io_data),
        .port_match_n_jumpers(wake_jumpers), .addr16_strap(addr16_strap),
        .width16_strap(width16_strap), .page_last_strap(page_last_strap),
        .irq_select_strap(irq_select_strap), .proc_fetch(proc_fetch),
        .proc_fetch_addr(proc_fetch_addr), .local_io_write(local_io_write),
        .local_io_addr(local_io_addr), .local_data_bit8(local_data_bit8),
        .port_match_n(port_match_n), .controller_reset_n(controller_reset_n),
        .attention_request(attention_request),
        .processor_attention_in(processor_attention_in),
        .switch_read_strobe_n(switch_read_strobe_n),
        .local_write_decode0_n(local_write_decode0_n), .fetch_ack(fetch_ack),
        .fetch_data(fetch_data), .first_attention_pending(first_attention_pending),
        .page_last(page_last), .interrupt_latch(interrupt_latch),
        .host_irq_n(host_irq_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h", $time, what, got);
        end
    endtask

    task automatic fetch(input logic [19:0] a);
        @(posedge clk);
        proc_fetch      <= 1'b1;
        proc_fetch_addr <= a;
        @(posedge clk);
        proc_fetch      <= 1'b0;
        proc_fetch_addr <= ~a;
        #1;
    endtask

    task automatic local_wr(input logic b8);
        @(posedge clk);
        local_io_write  <= 1'b1;
        local_io_addr   <= hwp_pkg::LOCAL_IRQ_PORT;
        local_data_bit8 <= b8;
        @(posedge clk);
        local_io_write  <= 1'b0;
        local_io_addr   <= ~hwp_pkg::LOCAL_IRQ_PORT;
        local_data_bit8 <= ~b8;
        #1;
    endtask

    // Whole run is about 140 cycles; this leaves a wide margin
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        reset = 1'b1;
        wake_jumpers = JW;
        jw_now = JW;
        addr16_strap = 1'b1;
        width16_strap = 1'b0;
        page_last_strap = 1'b0;
        irq_select_strap = 3'h0;
        proc_fetch = 1'b0;
        proc_fetch_addr = 20'h00000;
        local_io_write = 1'b0;
        local_io_addr = 16'h0000;
        local_data_bit8 = 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_bit(controller_reset_n, 1'b0, "reset level");
        chk_word({8'h00, host_irq_n}, 16'h00FF, "irq idle");
        host_u.port_write(JW ^ 16'h0100, hwp_pkg::CMD_CLEAR);
        chk_bit(port_match_n, 1'b1, "high byte compared");
        chk_bit(controller_reset_n, 1'b0, "no clear on miss");
        @(posedge clk) addr16_strap <= 1'b0;
        host_u.port_write(JW ^ 16'h0100, hwp_pkg::CMD_CLEAR);
        chk_bit(port_match_n, 1'b0, "high byte ignored");
        chk_bit(controller_reset_n, 1'b1, "clear releases");
        host_u.port_write(JW ^ 16'h0001, hwp_pkg::CMD_RESET);
        chk_bit(controller_reset_n, 1'b1, "low byte compared");
        host_u.port_write(JW, 8'h05);
        chk_bit(port_match_n, 1'b0, "match strobe");
        chk_bit(controller_reset_n, 1'b1, "unknown keeps run");
        chk_bit(attention_request, 1'b0, "unknown no attention");
        for (int w = 0; w < 2; w++) begin
            @(posedge clk);
            jw_now = w[0] ? JW : JW_ALT;
            wake_jumpers    <= jw_now;
            width16_strap   <= w[0];
            page_last_strap <= w[0];
            host_u.port_write(jw_now, hwp_pkg::CMD_RESET);
            chk_bit(controller_reset_n, 1'b0, "reset cmd");
            host_u.port_write(jw_now, hwp_pkg::CMD_ATTENTION);
            chk_bit(attention_request, 1'b1, "attention in reset");
            chk_bit(processor_attention_in, 1'b0, "attn gated");
            host_u.link(jw_now);
            chk_bit(attention_request, 1'b1, "attention");
            chk_bit(processor_attention_in, 1'b1, "proc attn");
            chk_bit(page_last, w[0], "page strap");
            fetch(hwp_pkg::ADDR_WIDTH_FETCH);
            chk_bit(fetch_ack, 1'b1, "width ack");
            chk_bit(fetch_data[0], w[0], "width strap");
            chk_bit(switch_read_strobe_n, 1'b1, "no strobe");
            chk_bit(first_attention_pending, 1'b1, "boot on");
            fetch(hwp_pkg::ADDR_ZERO_LO);
            chk_word(fetch_data, 16'h0000, "zero lo");
            fetch(hwp_pkg::ADDR_ZERO_HI);
            chk_bit(fetch_ack, 1'b1, "zero ack");
            chk_word(fetch_data, 16'h0000, "zero hi");
            fetch(hwp_pkg::ADDR_SWITCH_LO);
            chk_bit(switch_read_strobe_n, 1'b0, "switch strobe");
            chk_word(fetch_data, jw_now, "switch lo");
            fetch(hwp_pkg::ADDR_SWITCH_HI);
            chk_word(fetch_data, jw_now, "switch hi");
            @(posedge clk);
            #1;
            chk_bit(first_attention_pending, 1'b0, "boot off");
            host_u.port_write(jw_now, hwp_pkg::CMD_ATTENTION);
            chk_bit(attention_request, 1'b1, "later attention");
            fetch(hwp_pkg::ADDR_WIDTH_FETCH);
            chk_bit(fetch_ack, 1'b0, "no boot decode");
        end
        for (int s = 0; s < 8; s++) begin
            @(posedge clk) irq_select_strap <= s[2:0];
            local_wr(1'b1);
            chk_bit(local_write_decode0_n, 1'b0, "port decode");
            chk_bit(interrupt_latch, 1'b1, "latch set");
            @(posedge clk);
            #1;
            chk_word({8'h00, host_irq_n}, {8'h00, ~(8'h01 << s[2:0])}, "irq line");
            host_u.port_write(JW, hwp_pkg::CMD_CLEAR);
            chk_bit(interrupt_latch, 1'b0, "latch clear");
            @(posedge clk);
            #1;
            chk_word({8'h00, host_irq_n}, 16'h00FF, "irq released");
        end
        local_wr(1'b0);
        chk_bit(interrupt_latch, 1'b0, "bit8 low ignored");
        local_wr(1'b1);
        host_u.port_write(JW, 8'h03);
        chk_bit(interrupt_latch, 1'b1, "unknown keeps latch");
        host_u.port_write(JW, hwp_pkg::CMD_RESET);
        @(posedge clk);
        #1;
        chk_bit(interrupt_latch, 1'b0, "reset clears latch");
        chk_bit(controller_reset_n, 1'b0, "reset held low");
        host_u.port_write(JW, hwp_pkg::CMD_CLEAR);
        local_wr(1'b1);
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_bit(interrupt_latch, 1'b0, "mid reset latch");
        chk_bit(controller_reset_n, 1'b0, "mid reset level");
        chk_word({8'h00, host_irq_n}, 16'h00FF, "mid reset irq");
        complete_run();
    end
endmodule // hwp_port_match_n_bench

/* File: rtl/hwp_addr_cmp.sv */
// Wake-up address comparator for one address byte.
// Assumes address and jumper inputs synchronous to clk.
`timescale 1ns/10ps
module hwp_addr_cmp #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] addr,
    input  wire logic [WIDTH-1:0] jumper,
    input  wire logic             dont_care,
    output logic                  match
);
    if (WIDTH < 1) begin : g_width_check
        $error("hwp_addr_cmp needs a positive width");
    end

    assign match = dont_care | (addr == jumper);
endmodule // hwp_addr_cmp

/* File: rtl/hwp_pkg.sv */
// Package for the host wake-up port and boot decode block.
// Assumes a single 50 MHz clock domain and plain strap and bus ports.
package hwp_pkg;
    // Wake-up command bytes
    localparam logic [7:0] CMD_CLEAR     = 8'h00;
    localparam logic [7:0] CMD_ATTENTION = 8'h01;
    localparam logic [7:0] CMD_RESET     = 8'h02;
    // Boot fetch addresses answered locally
    localparam logic [19:0] ADDR_WIDTH_FETCH = 20'hFFFF6;
    localparam logic [19:0] ADDR_ZERO_LO     = 20'hFFFF8;
    localparam logic [19:0] ADDR_ZERO_HI     = 20'hFFFF9;
    localparam logic [19:0] ADDR_SWITCH_LO   = 20'hFFFFA;
    localparam logic [19:0] ADDR_SWITCH_HI   = 20'hFFFFB;
    // Local interrupt port
    localparam logic [15:0] LOCAL_IRQ_PORT   = 16'h0010;
    localparam int          LOCAL_IRQ_BIT    = 8;
    // Reset values
    localparam logic        RESET_CTRL_RST_N = 1'b0;
    localparam logic        RESET_ATTENTION  = 1'b0;
    localparam logic        RESET_IRQ_LATCH  = 1'b0;
    localparam logic [2:0]  RESET_IRQ_SEL    = 3'h0;
    // Switch value scale into the 20-bit wake-up block address
    localparam int          SWITCH_SHIFT     = 4;
    // Page select addresses
    localparam logic [3:0]  PAGE_FIRST       = 4'h0;
    localparam logic [3:0]  PAGE_LAST        = 4'hF;
endpackage

/* File: rtl/hwp_port_match_n.sv */
// Host wake-up port, boot fetch decode and host interrupt latch.
// Assumes host and processor strobes are one-cycle pulses synchronous to clk.
//
// Operation
// - Address match drives port match strobe
// - Decode clear, attention and reset commands
// - 8-bit addressing ignores high address byte
// - Reset command asserts controller reset low
// - Clear command releases controller reset
// - Page strap selects first or last page
// - Attention command raises processor attention input while controller reset is released
// - First attention fetch returns width strap
// - Width strap installed means 16-bit transfers
// - Local boot fetches return transfer acknowledge
// - Zero fetch location returns all zeros
// - Switch fetch strobes and returns jumpers
// - Later attentions skip wake-up block
// - Local port write sets interrupt latch
// - Clear command clears interrupt latch
// - Interrupt routed to strap-selected line
// - Controller reset clears latch and logic
`timescale 1ns/10ps
module hwp_port_match_n #(
    parameter int ADDR_W = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        host_io_write,
    input  wire logic [15:0] host_io_addr,
    input  wire logic [7:0]  host_io_data,
    input  wire logic [15:0] port_match_n_jumpers,
    input  wire logic        addr16_strap,
    input  wire logic        width16_strap,
    input  wire logic        page_last_strap,
    input  wire logic [2:0]  irq_select_strap,
    input  wire logic        proc_fetch,
    input  wire logic [19:0] proc_fetch_addr,
    input  wire logic        local_io_write,
    input  wire logic [15:0] local_io_addr,
    input  wire logic        local_data_bit8,
    output logic             port_match_n,
    output logic             controller_reset_n,
    output logic             attention_request,
    output logic             processor_attention_in,
    output logic             switch_read_strobe_n,
    output logic             local_write_decode0_n,
    output logic             fetch_ack,
    output logic [15:0]      fetch_data,
    output logic             first_attention_pending,
    output logic             page_last,
    output logic             interrupt_latch,
    output logic [7:0]       host_irq_n
);
    // Two byte-wide comparators cover the address, so only 16 bits fit
    if (ADDR_W != 16) begin : g_addr_w_check
        $error("hwp_port_match_n supports only 16-bit host I/O addresses");
    end

    typedef enum logic [1:0] {
        HWP_INIT_IDLE  = 2'b00,
        HWP_INIT_BOOT  = 2'b01,
        HWP_INIT_LINKED = 2'b10
    } hwp_init_t;

    hwp_init_t   init_reg;
    logic        match_lo;
    logic        match_hi;
    logic        port_hit;
    logic        cmd_clear;
    logic        cmd_attn;
    logic        cmd_reset;
    logic        irq_set;
    logic        boot_fetch;

    hwp_addr_cmp #(.WIDTH(8)) u_cmp_lo (
        .addr      (host_io_addr[7:0]),
        .jumper    (port_match_n_jumpers[7:0]),
        .dont_care (1'b0),
        .match     (match_lo)
    );
    hwp_addr_cmp #(.WIDTH(8)) u_cmp_hi (
        .addr      (host_io_addr[15:8]),
        .jumper    (port_match_n_jumpers[15:8]),
        .dont_care (~addr16_strap),
        .match     (match_hi)
    );

    assign port_hit  = host_io_write & match_lo & match_hi;
    assign cmd_clear = port_hit & (host_io_data == hwp_pkg::CMD_CLEAR);
    assign cmd_attn  = port_hit & (host_io_data == hwp_pkg::CMD_ATTENTION);
    assign cmd_reset = port_hit & (host_io_data == hwp_pkg::CMD_RESET);
    assign irq_set   = local_io_write & local_data_bit8
                     & (local_io_addr == hwp_pkg::LOCAL_IRQ_PORT);
    assign boot_fetch = proc_fetch & (init_reg == HWP_INIT_BOOT);

    // Port match strobe follows each matching host write for one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            port_match_n <= 1'b1;
        end else begin
            port_match_n <= ~port_hit;
        end
    end

    // Controller reset: reset command asserts, clear command releases
    always_ff @(posedge clk) begin
        if (reset) begin
            controller_reset_n <= hwp_pkg::RESET_CTRL_RST_N;
        end else if (cmd_reset) begin
            controller_reset_n <= 1'b0;
        end else if (cmd_clear) begin
            controller_reset_n <= 1'b1;
        end
    end

    // Attention is a one-cycle request; the processor input is held off while in controller reset
    always_ff @(posedge clk) begin
        if (reset) begin
            attention_request      <= hwp_pkg::RESET_ATTENTION;
            processor_attention_in <= hwp_pkg::RESET_ATTENTION;
        end else begin
            attention_request      <= cmd_attn;
            processor_attention_in <= cmd_attn & controller_reset_n;
        end
    end

    // Init tracking: first attention after controller reset is released enters boot decode
    always_ff @(posedge clk) begin
        if (reset || cmd_reset || !controller_reset_n) begin
            init_reg <= HWP_INIT_IDLE;
        end else begin
            unique case (init_reg)
                HWP_INIT_IDLE: begin
                    if (cmd_attn) init_reg <= HWP_INIT_BOOT;
                end
                HWP_INIT_BOOT: begin
                    // Switch fetch is last of boot sequence
                    if (proc_fetch && proc_fetch_addr == hwp_pkg::ADDR_SWITCH_HI)
                        init_reg <= HWP_INIT_LINKED;
                end
                HWP_INIT_LINKED: begin
                    init_reg <= HWP_INIT_LINKED;
                end
                default: init_reg <= HWP_INIT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            first_attention_pending <= 1'b0;
        end else begin
            first_attention_pending <= (init_reg == HWP_INIT_BOOT);
        end
    end

    // Local answers to boot fetches
    always_ff @(posedge clk) begin
        if (reset) begin
            fetch_ack            <= 1'b0;
            fetch_data           <= 16'h0000;
            switch_read_strobe_n <= 1'b1;
        end else begin
            fetch_ack            <= 1'b0;
            fetch_data           <= 16'h0000;
            switch_read_strobe_n <= 1'b1;
            if (boot_fetch) begin
                if (proc_fetch_addr == hwp_pkg::ADDR_WIDTH_FETCH) begin
                    fetch_ack     <= 1'b1;
                    fetch_data[0] <= width16_strap;
                end else if (proc_fetch_addr == hwp_pkg::ADDR_ZERO_LO ||
                             proc_fetch_addr == hwp_pkg::ADDR_ZERO_HI) begin
                    fetch_ack  <= 1'b1;
                    fetch_data <= 16'h0000;
                end else if (proc_fetch_addr == hwp_pkg::ADDR_SWITCH_LO ||
                             proc_fetch_addr == hwp_pkg::ADDR_SWITCH_HI) begin
                    fetch_ack            <= 1'b1;
                    switch_read_strobe_n <= 1'b0;
                    fetch_data           <= port_match_n_jumpers;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            page_last <= 1'b0;
        end else begin
            page_last <= page_last_strap;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            local_write_decode0_n <= 1'b1;
        end else begin
            local_write_decode0_n <= ~(local_io_write
                && local_io_addr == hwp_pkg::LOCAL_IRQ_PORT);
        end
    end

    // Interrupt latch: set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset || !controller_reset_n) begin
            interrupt_latch <= hwp_pkg::RESET_IRQ_LATCH;
        end else if (irq_set) begin
            interrupt_latch <= 1'b1;
        end else if (cmd_clear) begin
            interrupt_latch <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            host_irq_n <= 8'hFF;
        end else begin
            for (int i = 0; i < 8; i++) begin
                host_irq_n[i] <= ~(interrupt_latch && irq_select_strap == 3'(i));
            end
        end
    end

    // Assertions
    property p_match;
        @(posedge clk) disable iff (reset) port_hit |=> !port_match_n;
    endproperty
    a_match: assert property (p_match) else $error("port match missing");

    property p_reset_cmd;
        @(posedge clk) disable iff (reset) cmd_reset |=> !controller_reset_n;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset not asserted");

    property p_clear_cmd;
        @(posedge clk) disable iff (reset) (cmd_clear && !cmd_reset) |=> controller_reset_n;
    endproperty
    a_clear_cmd: assert property (p_clear_cmd) else $error("reset not released");

    property p_attn;
        @(posedge clk) disable iff (reset) cmd_attn |=> attention_request;
    endproperty
    a_attn: assert property (p_attn) else $error("attention missing");

    property p_width;
        @(posedge clk) disable iff (reset)
            (boot_fetch && proc_fetch_addr == hwp_pkg::ADDR_WIDTH_FETCH)
            |=> fetch_ack && fetch_data[0] == $past(width16_strap);
    endproperty
    a_width: assert property (p_width) else $error("width fetch wrong");

    property p_zero;
        @(posedge clk) disable iff (reset)
            (boot_fetch && proc_fetch_addr == hwp_pkg::ADDR_ZERO_LO)
            |=> fetch_ack && fetch_data == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero fetch wrong");

    property p_switch;
        @(posedge clk) disable iff (reset)
            (boot_fetch && proc_fetch_addr == hwp_pkg::ADDR_SWITCH_LO)
            |=> !switch_read_strobe_n && fetch_data == $past(port_match_n_jumpers);
    endproperty
    a_switch: assert property (p_switch) else $error("switch fetch wrong");

    sequence s_latch_up;
        interrupt_latch;
    endsequence

    sequence s_line_low;
        host_irq_n == ~(8'h01 << $past(irq_select_strap));
    endsequence

    property p_irq_set;
        @(posedge clk) disable iff (reset) (irq_set && controller_reset_n)
            |=> s_latch_up ##1 s_line_low;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not raised");

    property p_irq_clr;
        @(posedge clk) disable iff (reset) (cmd_clear && !irq_set) |=> !interrupt_latch;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");

    property p_unknown;
        @(posedge clk) disable iff (reset)
            (port_hit && host_io_data > hwp_pkg::CMD_RESET && !irq_set)
            |=> $stable(controller_reset_n) && !attention_request
                && $stable(interrupt_latch);
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown cmd acted");

    sequence s_boot_entered;
        (init_reg == HWP_INIT_BOOT) ##1 first_attention_pending;
    endsequence

    property p_boot_entry;
        @(posedge clk) disable iff (reset)
            (cmd_attn && controller_reset_n && init_reg == HWP_INIT_IDLE)
            |=> s_boot_entered;
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("boot not entered");

    // An attention in controller reset must not reach the held processor
    property p_attn_gate;
        @(posedge clk) disable iff (reset)
            (cmd_attn && !controller_reset_n)
            |=> attention_request && !processor_attention_in;
    endproperty
    a_attn_gate: assert property (p_attn_gate) else $error("attention not gated");

    property p_no_boot;
        @(posedge clk) disable iff (reset)
            (proc_fetch && init_reg != HWP_INIT_BOOT)
            |=> !fetch_ack && switch_read_strobe_n;
    endproperty
    a_no_boot: assert property (p_no_boot) else $error("fetch answered outside boot");

    property p_zero_hi;
        @(posedge clk) disable iff (reset)
            (boot_fetch && proc_fetch_addr == hwp_pkg::ADDR_ZERO_HI)
            |=> fetch_ack && fetch_data == 16'h0000;
    endproperty
    a_zero_hi: assert property (p_zero_hi) else $error("zero hi fetch wrong");

    property p_switch_hi;
        @(posedge clk) disable iff (reset)
            (boot_fetch && proc_fetch_addr == hwp_pkg::ADDR_SWITCH_HI)
            |=> fetch_ack && !switch_read_strobe_n
                && fetch_data == $past(port_match_n_jumpers);
    endproperty
    a_switch_hi: assert property (p_switch_hi) else $error("switch hi fetch wrong");

    property p_decode0;
        @(posedge clk) disable iff (reset)
            (local_io_write && local_io_addr == hwp_pkg::LOCAL_IRQ_PORT)
            |=> !local_write_decode0_n;
    endproperty
    a_decode0: assert property (p_decode0) else $error("port decode missing");

    property p_irq_line;
        @(posedge clk) disable iff (reset)
            interrupt_latch |=> host_irq_n == ~(8'h01 << $past(irq_select_strap));
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("wrong irq line");

    property p_irq_idle;
        @(posedge clk) disable iff (reset) !interrupt_latch |=> host_irq_n == 8'hFF;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq line not released");

    property p_ctrl_hold;
        @(posedge clk) disable iff (reset)
            !controller_reset_n |=> !interrupt_latch && init_reg == HWP_INIT_IDLE;
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("reset hold broken");

    property p_page;
        @(posedge clk) disable iff (reset) 1'b1 |=> page_last == $past(page_last_strap);
    endproperty
    a_page: assert property (p_page) else $error("page strap not followed");
endmodule // hwp_port_match_n
